//--- prst_top.sv
// peripheral reset-state register block with ahb-lite slave
// Notes on behaviour
// - scratch words 0F8H..0FDH hold undefined data after any reset.
// - reset in standby keeps shift, slave address and bit buffers.
// - reset in operation leaves those registers undefined (filled pattern).
// - serial mode and serial bus control registers clear to zero.
// - processor clock, system clock and clock output mode clear to zero.
// - port buffers off, latches zero, direction and pull-up registers zero.
// - adc mode loads 04H; approximation result is undefined.
// - interrupt enables, master enable, edge modes zero; ext 1,2,4 requests undefined.
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module prst_top (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // standby indication from the power controller
  input  wire logic        i_standby,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // digital port pins
  output logic [7:0]       o_port_out,
  output logic [7:0]       o_port_oe
);
  import prst_pkg::*;

  // standby pin synchroniser; first stage is read only by the second. no reset
  // here: it keeps tracking the pin while reset is low, otherwise the standby
  // state at reset entry is lost before the retention decision is taken
  logic sb_meta;
  logic sb_sync;
  always_ff @(posedge i_clock) begin
    sb_meta <= i_standby;
    sb_sync <= sb_meta;
  end

  // reset-entry capture: standby level is latched each cycle and sampled
  // by the first clocked cycle after release, which then decides retention
  logic       was_standby;
  logic       next_was_standby;
  logic       first_cycle;
  logic       last_standby;
  logic       next_last_standby;
  always_comb begin
    next_last_standby = sb_sync;
    next_was_standby  = first_cycle ? last_standby : was_standby;
  end
  // last_standby carries no reset so it still reflects the state before reset
  always_ff @(posedge i_clock) begin
    last_standby <= next_last_standby;
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_cycle <= 1'b1;
      was_standby <= 1'b0;
    end else begin
      first_cycle <= 1'b0;
      was_standby <= next_was_standby;
    end
  end

  // bus address phase capture
  logic       dp_valid;
  logic       dp_write;
  logic [7:0] dp_addr;
  logic       next_dp_valid;
  logic       next_dp_write;
  logic [7:0] next_dp_addr;
  always_comb begin
    next_dp_valid = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ)
                    && (i_hsize == HSIZE_WORD);
    next_dp_write = i_hwrite;
    next_dp_addr  = i_haddr;
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= ZERO_RESET;
    end else begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr  <= next_dp_addr;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wr;
  assign wr = dp_valid && dp_write;

  // registers set on every reset: zero, except adc mode 04H and fill in ext request bits
  logic [7:0]  serial_operating_mode_register, serial_bus_control_register;
  logic [7:0]  processor_clock_control, system_clock_control;
  logic [7:0]  clock_output_mode_register;
  logic [7:0]  interrupt_request_flags, interrupt_enable_flags;
  logic        interrupt_master_enable;
  logic [1:0]  ext_int0_edge_mode, ext_int1_edge_mode, ext_int2_edge_mode;
  logic [7:0]  port_latch, port_direction_group_a, port_direction_group_b;
  logic [7:0]  pull_up_select_register, adc_mode_register;
  logic [7:0]  next_sm, next_sb, next_pc, next_sc, next_co, next_ir;
  logic [7:0]  next_ie, next_pl, next_da, next_db, next_pu, next_ad;
  logic        next_ime;
  logic [1:0]  next_im0, next_im1, next_im2;
  always_comb begin
    next_sm = wr && hit(dp_addr, SERIAL_MODE_OFS) ? i_hwdata[7:0] : serial_operating_mode_register;
    next_sb = wr && hit(dp_addr, SERIAL_BUS_OFS) ? i_hwdata[7:0] : serial_bus_control_register;
    next_pc = wr && hit(dp_addr, PROC_CLOCK_OFS) ? i_hwdata[7:0] : processor_clock_control;
    next_sc = wr && hit(dp_addr, SYS_CLOCK_OFS) ? i_hwdata[7:0] : system_clock_control;
    next_co = wr && hit(dp_addr, CLOCK_OUT_OFS) ? i_hwdata[7:0] : clock_output_mode_register;
    next_ir = wr && hit(dp_addr, INT_REQ_OFS) ? i_hwdata[7:0] : interrupt_request_flags;
    next_ie = wr && hit(dp_addr, INT_EN_OFS) ? i_hwdata[7:0] : interrupt_enable_flags;
    next_pl = wr && hit(dp_addr, PORT_LATCH_OFS) ? i_hwdata[7:0] : port_latch;
    next_da = wr && hit(dp_addr, PORT_DIR_A_OFS) ? i_hwdata[7:0] : port_direction_group_a;
    next_db = wr && hit(dp_addr, PORT_DIR_B_OFS) ? i_hwdata[7:0] : port_direction_group_b;
    next_pu = wr && hit(dp_addr, PULL_UP_OFS) ? i_hwdata[7:0] : pull_up_select_register;
    next_ad = wr && hit(dp_addr, ADC_MODE_OFS) ? i_hwdata[7:0] : adc_mode_register;
    next_ime = interrupt_master_enable;
    next_im0 = ext_int0_edge_mode;
    next_im1 = ext_int1_edge_mode;
    next_im2 = ext_int2_edge_mode;
    if (wr && hit(dp_addr, INT_CTRL_OFS)) begin
      next_ime = i_hwdata[IME_BIT];
      next_im0 = i_hwdata[IM0_LSB +: 2];
      next_im1 = i_hwdata[IM1_LSB +: 2];
      next_im2 = i_hwdata[IM2_LSB +: 2];
    end
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      serial_operating_mode_register <= ZERO_RESET;
      serial_bus_control_register    <= ZERO_RESET;
      processor_clock_control        <= ZERO_RESET;
      system_clock_control           <= ZERO_RESET;
      clock_output_mode_register     <= ZERO_RESET;
      interrupt_request_flags        <= UNDEF_FILL & IRQ_KEEP_MASK;
      interrupt_enable_flags         <= ZERO_RESET;
      interrupt_master_enable        <= 1'b0;
      ext_int0_edge_mode             <= 2'h0;
      ext_int1_edge_mode             <= 2'h0;
      ext_int2_edge_mode             <= 2'h0;
      port_latch                     <= ZERO_RESET;
      port_direction_group_a         <= ZERO_RESET;
      port_direction_group_b         <= ZERO_RESET;
      pull_up_select_register        <= ZERO_RESET;
      adc_mode_register              <= ADC_MODE_RESET;
    end else begin
      serial_operating_mode_register <= next_sm;
      serial_bus_control_register    <= next_sb;
      processor_clock_control        <= next_pc;
      system_clock_control           <= next_sc;
      clock_output_mode_register     <= next_co;
      interrupt_request_flags        <= next_ir;
      interrupt_enable_flags         <= next_ie;
      interrupt_master_enable        <= next_ime;
      ext_int0_edge_mode             <= next_im0;
      ext_int1_edge_mode             <= next_im1;
      ext_int2_edge_mode             <= next_im2;
      port_latch                     <= next_pl;
      port_direction_group_a         <= next_da;
      port_direction_group_b         <= next_db;
      pull_up_select_register        <= next_pu;
      adc_mode_register              <= next_ad;
    end
  end

  // retained registers: no async reset, so standby contents survive; after a
  // reset from operation the first cycle overwrites shift, slave address and bit buffers with a fill pattern
  logic [7:0]  serial_shift_register, serial_slave_address_register;
  logic [7:0]  successive_approximation_result;
  logic [15:0] bit_sequential_buffers;
  logic [7:0]  next_ss, next_sv, next_sa;
  logic [15:0] next_bb;
  always_comb begin
    next_ss = wr && hit(dp_addr, SERIAL_SHIFT_OFS) ? i_hwdata[7:0] : serial_shift_register;
    next_sv = wr && hit(dp_addr, SERIAL_SLAVE_OFS) ? i_hwdata[7:0] : serial_slave_address_register;
    next_bb = wr && hit(dp_addr, BIT_BUF_OFS) ? i_hwdata[15:0] : bit_sequential_buffers;
    next_sa = successive_approximation_result;
    if (first_cycle && !last_standby) begin
      next_ss = UNDEF_FILL;
      next_sv = UNDEF_FILL;
      next_bb = {UNDEF_FILL, UNDEF_FILL};
    end
  end
  // kept during reset when entered from standby
  always_ff @(posedge i_clock) begin
    if (i_reset_n) begin
      serial_shift_register           <= next_ss;
      serial_slave_address_register   <= next_sv;
      bit_sequential_buffers          <= next_bb;
    end
    successive_approximation_result <= next_sa;
  end

  // scratch window 0F8H..0FDH, not initialised by reset; bus reads of it
  // return zero in this version, so its read port is left unconnected
  logic       sc_hit;
  assign sc_hit = (dp_addr[7:5] == SCRATCH_BASE_OFS[7:5]) && (dp_addr[4:2] < 3'h6);
  prst_scratch_mem #(.WORDS(SCRATCH_WORDS), .AW(3)) u_scratch (
    .i_clock (i_clock),
    .i_write (wr && sc_hit),
    .i_waddr (dp_addr[4:2]),
    .i_wdata (i_hwdata[7:0]),
    .i_raddr (dp_addr[4:2]),
    .o_rdata ()
  );

  // read mux and pin outputs, all registered
  logic [31:0] next_hrdata;
  logic [7:0]  next_port_oe;
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_dp_valid && !i_hwrite) begin
      case (i_haddr)
        SERIAL_MODE_OFS:  next_hrdata[7:0]  = next_sm;
        SERIAL_BUS_OFS:   next_hrdata[7:0]  = next_sb;
        SERIAL_SHIFT_OFS: next_hrdata[7:0]  = next_ss;
        SERIAL_SLAVE_OFS: next_hrdata[7:0]  = next_sv;
        PROC_CLOCK_OFS:   next_hrdata[7:0]  = next_pc;
        SYS_CLOCK_OFS:    next_hrdata[7:0]  = next_sc;
        CLOCK_OUT_OFS:    next_hrdata[7:0]  = next_co;
        INT_REQ_OFS:      next_hrdata[7:0]  = next_ir;
        INT_EN_OFS:       next_hrdata[7:0]  = next_ie;
        INT_CTRL_OFS:     next_hrdata[15:0] = {2'h0, next_im2, 2'h0, next_im1,
                                               2'h0, next_im0, 3'h0, next_ime};
        PORT_LATCH_OFS:   next_hrdata[7:0]  = next_pl;
        PORT_DIR_A_OFS:   next_hrdata[7:0]  = next_da;
        PORT_DIR_B_OFS:   next_hrdata[7:0]  = next_db;
        PULL_UP_OFS:      next_hrdata[7:0]  = next_pu;
        ADC_MODE_OFS:     next_hrdata[7:0]  = next_ad;
        ADC_RESULT_OFS:   next_hrdata[7:0]  = next_sa;
        BIT_BUF_OFS:      next_hrdata[15:0] = next_bb;
        STATUS_OFS:       next_hrdata[1:0]  = {next_was_standby, sb_sync};
        default:          next_hrdata       = 32'h0000_0000;
      endcase
    end
    // direction bit 1 means output; group a drives, group b must also agree
    next_port_oe = next_da & next_db;
  end
  // bus answer and pins; the slave never stalls and always answers okay
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hrdata    <= 32'h0000_0000;
      o_port_out  <= ZERO_RESET;
      o_port_oe   <= ZERO_RESET;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hrdata    <= next_hrdata;
      o_port_out  <= next_pl;
      o_port_oe   <= next_port_oe;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end
endmodule

//--- prst_pkg.sv
// package with register map, field layout and reset values of the peripheral reset-state block
package prst_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] SERIAL_MODE_OFS   = 8'h00;
  localparam logic [7:0] SERIAL_BUS_OFS    = 8'h04;
  localparam logic [7:0] SERIAL_SHIFT_OFS  = 8'h08;
  localparam logic [7:0] SERIAL_SLAVE_OFS  = 8'h0C;
  localparam logic [7:0] PROC_CLOCK_OFS    = 8'h10;
  localparam logic [7:0] SYS_CLOCK_OFS     = 8'h14;
  localparam logic [7:0] CLOCK_OUT_OFS     = 8'h18;
  localparam logic [7:0] INT_REQ_OFS       = 8'h1C;
  localparam logic [7:0] INT_EN_OFS        = 8'h20;
  localparam logic [7:0] INT_CTRL_OFS      = 8'h24;
  localparam logic [7:0] PORT_LATCH_OFS    = 8'h28;
  localparam logic [7:0] PORT_DIR_A_OFS    = 8'h2C;
  localparam logic [7:0] PORT_DIR_B_OFS    = 8'h30;
  localparam logic [7:0] PULL_UP_OFS       = 8'h34;
  localparam logic [7:0] ADC_MODE_OFS      = 8'h38;
  localparam logic [7:0] ADC_RESULT_OFS    = 8'h3C;
  localparam logic [7:0] BIT_BUF_OFS       = 8'h40;
  localparam logic [7:0] STATUS_OFS        = 8'h44;
  localparam logic [7:0] SCRATCH_BASE_OFS  = 8'h80;
  // scratch data memory window, words 0F8H..0FDH
  localparam int         SCRATCH_WORDS     = 6;
  localparam logic [7:0] SCRATCH_FIRST     = 8'hF8;
  // reset values
  localparam logic [7:0] ZERO_RESET        = 8'h00;
  localparam logic [7:0] ADC_MODE_RESET    = 8'h04;
  localparam logic [7:0] UNDEF_FILL        = 8'hA5;
  // interrupt request bit positions that are left undefined
  localparam int         IRQ_EXT1_BIT      = 1;
  localparam int         IRQ_EXT2_BIT      = 2;
  localparam int         IRQ_EXT4_BIT      = 4;
  localparam logic [7:0] IRQ_KEEP_MASK     = 8'h16;
  // interrupt control field positions
  localparam int         IME_BIT           = 0;
  localparam int         IM0_LSB           = 4;
  localparam int         IM1_LSB           = 8;
  localparam int         IM2_LSB           = 12;
  // status field positions
  localparam int         STAT_STANDBY_BIT  = 0;
  localparam int         STAT_WARM_BIT     = 1;
  // ahb-lite codes
  localparam logic [1:0] HTRANS_NONSEQ     = 2'h2;
  localparam logic [2:0] HSIZE_WORD        = 3'h2;
  typedef enum logic [1:0] {PRST_ADDR, PRST_DATA} prst_phase_t;
endpackage

//--- prst_scratch_mem.sv
// small scratch memory with registered read data, contents never reset
`timescale 1ns/100ps
module prst_scratch_mem #(
  parameter int WORDS = 6,
  parameter int AW    = 3
) (
  // clock
  input  wire logic          i_clock,
  // write port
  input  wire logic          i_write,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  // read port
  input  wire logic [AW-1:0] i_raddr,
  output logic [7:0]         o_rdata
);
  logic [7:0] mem [WORDS];

  // no reset: contents after reset are undefined by design
  always_ff @(posedge i_clock) begin
    if (i_write) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

//--- prst_top_properties.sv
// concurrent checks of the reset state seen at the block's bus and port pins
`timescale 1ns/100ps
module prst_checker (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  // bus
  input wire logic        i_hsel,
  input wire logic [7:0]  i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [2:0]  i_hsize,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  // port pins
  input wire logic [7:0]  o_port_out,
  input wire logic [7:0]  o_port_oe
);
  import prst_pkg::*;
  logic       take;
  logic       clean;
  logic       rd_pend;
  logic [7:0] rd_ofs;
  assign take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && i_hsize == HSIZE_WORD;
  // clean stays set until the first accepted write, so reads see pure reset values
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clean   <= 1'b1;
      rd_pend <= 1'b0;
      rd_ofs  <= 8'h00;
    end else begin
      clean   <= clean && !(take && i_hwrite);
      rd_pend <= take && !i_hwrite;
      rd_ofs  <= i_haddr;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  mode_clear_a: assert property (
    rd_pend && clean && rd_ofs == SERIAL_MODE_OFS |-> o_hrdata == 32'h0)
    else $error("serial mode not zero after reset");
  bus_ctl_clear_a: assert property (
    take && !i_hwrite && clean && i_haddr == SERIAL_BUS_OFS |=> o_hrdata == 32'h0)
    else $error("serial bus control not zero after reset");
  clock_clear_a: assert property (
    take && !i_hwrite && clean && (i_haddr == PROC_CLOCK_OFS || i_haddr == SYS_CLOCK_OFS
    || i_haddr == CLOCK_OUT_OFS) |=> o_hrdata == 32'h0)
    else $error("clock register not zero after reset");
  port_regs_clear_a: assert property (
    rd_pend && clean && rd_ofs >= PORT_LATCH_OFS && rd_ofs <= PULL_UP_OFS
    |-> o_hrdata == 32'h0)
    else $error("port register not zero after reset");
  port_off_a: assert property (
    $rose(i_reset_n) |-> o_port_oe == 8'h00 && o_port_out == 8'h00)
    else $error("port driven at reset release");
  buffers_off_a: assert property (clean |-> o_port_oe == 8'h00)
    else $error("port buffer on before any write");
  adc_mode_init_a: assert property (
    rd_pend && clean && rd_ofs == ADC_MODE_OFS |-> o_hrdata == {24'h0, ADC_MODE_RESET})
    else $error("adc mode not 04 after reset");
  irq_clear_a: assert property (
    rd_pend && clean && rd_ofs == INT_REQ_OFS
    |-> (o_hrdata & ~{24'h0, IRQ_KEEP_MASK}) == 32'h0)
    else $error("request flag set after reset");
  int_ctl_clear_a: assert property (
    rd_pend && clean && (rd_ofs == INT_EN_OFS || rd_ofs == INT_CTRL_OFS)
    |-> o_hrdata == 32'h0)
    else $error("interrupt enable or mode not zero after reset");
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("slave stalled or answered error");
endmodule
bind prst_top prst_checker chk (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_port_out(o_port_out), .o_port_oe(o_port_oe));

//--- prst_reset_source.sv
// behavioural reset pin source that can reset the device in standby or in operation
`timescale 1ns/100ps
module prst_reset_source (
  // control from the bench
  input  wire logic i_clock,
  input  wire logic i_go,
  input  wire logic i_in_standby,
  // reset pin and standby indication
  output logic      o_reset_n,
  output logic      o_standby,
  output logic      o_busy
);
  // power-up reset of five cycles, then one pulse per request
  initial begin
    o_reset_n = 1'b0;
    o_standby = 1'b0;
    o_busy    = 1'b1;
    repeat (5) @(posedge i_clock);
    o_reset_n <= 1'b1;
    o_busy    <= 1'b0;
    forever begin
      @(posedge i_clock);
      if (i_go) begin
        o_busy    <= 1'b1;
        o_standby <= i_in_standby;
        // the device syncs standby over two flops, so give it time first
        repeat (4) @(posedge i_clock);
        o_reset_n <= 1'b0;
        repeat (3) @(posedge i_clock);
        o_reset_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        o_standby <= 1'b0;
        o_busy    <= 1'b0;
      end
    end
  end
endmodule

//--- peripheral_reset_state_tb_top.sv
// self-checking bench for the peripheral reset-state block
`timescale 1ns/100ps
module peripheral_reset_state_tb_top;
  import prst_pkg::*;
  localparam logic [7:0] CLR [11] = '{SERIAL_MODE_OFS, SERIAL_BUS_OFS, PROC_CLOCK_OFS,
    SYS_CLOCK_OFS, CLOCK_OUT_OFS, INT_EN_OFS, INT_CTRL_OFS, PORT_LATCH_OFS, PORT_DIR_A_OFS,
    PORT_DIR_B_OFS, PULL_UP_OFS};
  // bits that the interrupt control word really stores
  localparam logic [31:0] CTL_MASK = (32'h1 << IME_BIT) | (32'h3 << IM0_LSB)
    | (32'h3 << IM1_LSB) | (32'h3 << IM2_LSB);
  logic        i_clock = 1'b0;
  logic        go      = 1'b0;
  logic        in_sb   = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [7:0]  haddr   = 8'h00;
  logic [1:0]  htrans  = 2'h0;
  logic [2:0]  hsize   = 3'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata, rd;
  logic        busy, rst_n, sb, hready, hresp;
  logic [7:0]  port_out, port_oe;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          cycles     = 0;
  int unsigned exp [logic [7:0]];

  always #2.5 i_clock = ~i_clock;

  prst_reset_source src (.i_clock(i_clock), .i_go(go), .i_in_standby(in_sb),
    .o_reset_n(rst_n), .o_standby(sb), .o_busy(busy));
  prst_top uut (.i_clock(i_clock), .i_reset_n(rst_n), .i_standby(sb), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_port_out(port_out), .o_port_oe(port_oe));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // the run should need well under a thousand cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // one single word transfer; read data taken at the edge closing the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    hsize  <= HSIZE_WORD;
    @(posedge i_clock);
    while (hready !== 1'b1) @(posedge i_clock);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge i_clock);
    while (hready !== 1'b1) @(posedge i_clock);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    exp[a] = (a == INT_CTRL_OFS) ? (d & CTL_MASK) : d;
  endtask

  task automatic rd_chk(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    check(rd, exp[a]);
  endtask

  // reference reset state; fills stand in for undefined contents
  function automatic void model_reset(input bit standby);
    foreach (CLR[k]) exp[CLR[k]] = 0;
    exp[ADC_MODE_OFS] = ADC_MODE_RESET;
    exp[INT_REQ_OFS]  = UNDEF_FILL & IRQ_KEEP_MASK;
    exp[STATUS_OFS]   = standby ? (32'h1 << STAT_WARM_BIT) : 32'h0;
    if (!standby) begin
      exp[SERIAL_SHIFT_OFS] = UNDEF_FILL;
      exp[SERIAL_SLAVE_OFS] = UNDEF_FILL;
      exp[BIT_BUF_OFS]      = {UNDEF_FILL, UNDEF_FILL};
    end
  endfunction

  task automatic reset_state_chk;
    foreach (CLR[k]) rd_chk(CLR[k]);
    rd_chk(INT_REQ_OFS);
    rd_chk(ADC_MODE_OFS);
    rd_chk(SERIAL_SHIFT_OFS);
    rd_chk(SERIAL_SLAVE_OFS);
    rd_chk(BIT_BUF_OFS);
    rd_chk(STATUS_OFS);
    check(port_out, 32'h0);
    check(port_oe, 32'h0);
  endtask

  initial begin
    void'($urandom(31936));
    while (busy !== 1'b0) @(posedge i_clock);
    @(posedge i_clock);
    model_reset(1'b0);
    reset_state_chk();
    bus(1'b0, 8'h60, 32'h0);
    check(rd, 32'h0);
    $display("test power_up done");
    // load the cleared and retained registers, then reset in standby, operation, standby
    for (int n = 0; n < 3; n++) begin
      foreach (CLR[k]) wr(CLR[k], $urandom_range(CLR[k] == INT_CTRL_OFS ? 65535 : 255, 1));
      wr(SERIAL_SHIFT_OFS, $urandom_range(255));
      wr(SERIAL_SLAVE_OFS, $urandom_range(255));
      wr(BIT_BUF_OFS, $urandom_range(65535));
      // read back so that the following reset really has something to clear
      foreach (CLR[k]) rd_chk(CLR[k]);
      rd_chk(PORT_LATCH_OFS);
      check(port_out, exp[PORT_LATCH_OFS]);
      check(port_oe, exp[PORT_DIR_A_OFS] & exp[PORT_DIR_B_OFS]);
      rd_chk(BIT_BUF_OFS);
      in_sb <= (n != 1);
      go    <= 1'b1;
      @(posedge i_clock);
      go    <= 1'b0;
      @(posedge i_clock);
      while (busy === 1'b1) @(posedge i_clock);
      model_reset(n != 1);
      reset_state_chk();
      $display("test reset pass %0d done", n);
    end
    give_verdict();
  end
endmodule
